/* lnb_host_model.sv */
// host register master model driving the byte-wide register bus
module lnb_host_model
	import lnb_protection_diag_pkg::*;
(
	input  wire logic              i_clk_sys,
	input  wire logic [DATA_W-1:0] i_reg_rdata,
	output logic                   o_reg_wr,
	output logic      [ADDR_W-1:0] o_reg_addr,
	output logic      [DATA_W-1:0] o_reg_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_reg_wr = 1'b0;
		o_reg_addr = 8'h00;
		o_reg_wdata = 8'h00;
	end
	// one byte write; data line shows the inverse once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		o_reg_wr <= 1'b1;
		o_reg_addr <= a;
		o_reg_wdata <= d;
		@(posedge i_clk_sys);
		o_reg_wr <= 1'b0;
		o_reg_wdata <= ~d;
	endtask
	// one byte read, answer one cycle after the address is taken
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk_sys);
		o_reg_addr <= a;
		@(posedge i_clk_sys);
		#1 d = i_reg_rdata;
	endtask
endmodule

/* lnb_protection_diag_pkg.sv */
// constants for the antenna supply protection and diagnostic registers
// Contract
// - protection control register sits at address 0x5, writable and readable
// - overload restart mode set: overload clears channel select bits, output off
// - thermal restart mode set: overheat clears all select bits, output off
// - thermal restart mode clear: keep selects, output returns after overheat
// - both status registers are read only; writes to them are ignored
// - status address 0x0: bit 0 channel a overload, bit 1 channel b
// - status bit 6 reports junction overtemperature
// - status bit 7 reads 1 while input supply is below threshold
// - secondary status at address 0x1 is readable, all bits reserved
// - reset clears control register and both status registers to zero
// - select bits live at address 0x2: channel a low nibble, b high
// - all four select bits zero puts that channel in standby
// - reading a read/write register returns the byte last written; the select register reads back with protection-cleared bits as zero
package lnb_protection_diag_pkg;
	localparam int          DATA_W             = 8;
	localparam int          ADDR_W             = 8;
	localparam int          VOLTAGE_SELECT_BITS_W             = 4;
	localparam int          COND_W             = 4;

	localparam logic [7:0]  ADDR_STATUS_PRI    = 8'h00;
	localparam logic [7:0]  ADDR_STATUS_SEC    = 8'h01;
	localparam logic [7:0]  ADDR_VOLTAGE_SELECT_BITS          = 8'h02;
	localparam logic [7:0]  ADDR_PROT_CTRL     = 8'h05;

	localparam logic [7:0]  RESET_PROT_CTRL    = 8'h00;
	localparam logic [7:0]  RESET_VOLTAGE_SELECT_BITS         = 8'h00;
	localparam logic [7:0]  READ_UNMAPPED      = 8'h00;
	localparam logic [7:0]  STATUS_SEC_VALUE   = 8'h00;
	localparam logic [3:0]  VOLTAGE_SELECT_BITS_STANDBY       = 4'h0;
	localparam logic [3:0]  COND_IDLE          = 4'h0;

	localparam int          BIT_OVERLOAD_RST   = 3;
	localparam int          BIT_THERMAL_RST    = 6;
	localparam int          VOLTAGE_SELECT_BITS_A_LSB         = 0;
	localparam int          VOLTAGE_SELECT_BITS_B_LSB         = 4;

	localparam int          BIT_OC_A           = 0;
	localparam int          BIT_OC_B           = 1;
	localparam int          BIT_OVERHEAT       = 6;
	localparam int          BIT_LOW_SUPPLY     = 7;

	localparam int          COND_OC_A          = 0;
	localparam int          COND_OC_B          = 1;
	localparam int          COND_OVERHEAT      = 2;
	localparam int          COND_LOW_SUPPLY    = 3;
endpackage

/* lnb_protection_diag_regs.sv */
// protection control, voltage select and diagnostic status register logic
module lnb_protection_diag_regs
	import lnb_protection_diag_pkg::*;
(
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst,
	input  wire logic              i_reg_wr,
	input  wire logic [ADDR_W-1:0] i_reg_addr,
	input  wire logic [DATA_W-1:0] i_reg_wdata,
	output logic      [DATA_W-1:0] o_reg_rdata,
	input  wire logic              i_overcurrent_chan_a,
	input  wire logic              i_overcurrent_chan_b,
	input  wire logic              i_overheat,
	input  wire logic              i_low_supply,
	output logic      [VOLTAGE_SELECT_BITS_W-1:0] o_voltage_select_a,
	output logic      [VOLTAGE_SELECT_BITS_W-1:0] o_voltage_select_b,
	output logic                   o_supply_enable_a,
	output logic                   o_supply_enable_b
);

	logic [COND_W-1:0] cond_meta;
	logic [COND_W-1:0] cond_sync;
	logic [DATA_W-1:0] prot_ctrl;
	logic [DATA_W-1:0] voltage_select_bits;
	logic [DATA_W-1:0] status_pri;
	logic [DATA_W-1:0] next_rdata;
	logic              overcurrent_flag_chan_a;
	logic              overcurrent_flag_chan_b;
	logic              overheat_flag;
	logic              low_supply_flag;
	logic              overload_restart_mode;
	logic              thermal_restart_mode;
	logic              wr_voltage_select_bits;
	logic              wr_ctrl;
	logic              next_enable_a;
	logic              next_enable_b;

	function automatic logic chan_active(input logic [VOLTAGE_SELECT_BITS_W-1:0] sel);
		chan_active = (sel != VOLTAGE_SELECT_BITS_STANDBY);
	endfunction

	// condition comparators arrive from the analog side
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			cond_meta <= COND_IDLE;
			cond_sync <= COND_IDLE;
		end else begin
			cond_meta <= {i_low_supply, i_overheat,
				i_overcurrent_chan_b, i_overcurrent_chan_a};
			cond_sync <= cond_meta;
		end
	end

	// flags mirror the synchronised condition, no latching
	assign overcurrent_flag_chan_a = cond_sync[COND_OC_A];
	assign overcurrent_flag_chan_b = cond_sync[COND_OC_B];
	assign overheat_flag           = cond_sync[COND_OVERHEAT];
	assign low_supply_flag         = cond_sync[COND_LOW_SUPPLY];

	always_comb begin
		status_pri                 = 8'h00;
		status_pri[BIT_OC_A]       = overcurrent_flag_chan_a;
		status_pri[BIT_OC_B]       = overcurrent_flag_chan_b;
		status_pri[BIT_OVERHEAT]   = overheat_flag;
		status_pri[BIT_LOW_SUPPLY] = low_supply_flag;
	end

	// only data registers decode writes; status addresses never do
	assign wr_ctrl = i_reg_wr && (i_reg_addr == ADDR_PROT_CTRL);
	assign wr_voltage_select_bits = i_reg_wr && (i_reg_addr == ADDR_VOLTAGE_SELECT_BITS);

	assign overload_restart_mode = prot_ctrl[BIT_OVERLOAD_RST];
	assign thermal_restart_mode  = prot_ctrl[BIT_THERMAL_RST];

	// control byte stored whole so it reads back as written
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			prot_ctrl <= RESET_PROT_CTRL;
		end else if (wr_ctrl) begin
			prot_ctrl <= i_reg_wdata;
		end
	end

	// select bits: protection clears win over a same-cycle host write
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			voltage_select_bits <= RESET_VOLTAGE_SELECT_BITS;
		end else begin
			if (wr_voltage_select_bits) begin
				voltage_select_bits <= i_reg_wdata;
			end
			if (overload_restart_mode && overcurrent_flag_chan_a) begin
				voltage_select_bits[VOLTAGE_SELECT_BITS_A_LSB +: VOLTAGE_SELECT_BITS_W] <= VOLTAGE_SELECT_BITS_STANDBY;
			end
			if (overload_restart_mode && overcurrent_flag_chan_b) begin
				voltage_select_bits[VOLTAGE_SELECT_BITS_B_LSB +: VOLTAGE_SELECT_BITS_W] <= VOLTAGE_SELECT_BITS_STANDBY;
			end
			if (thermal_restart_mode && overheat_flag) begin
				voltage_select_bits <= RESET_VOLTAGE_SELECT_BITS;
			end
		end
	end

	// output is held off during overheat and resumes with kept selects
	assign next_enable_a = chan_active(voltage_select_bits[VOLTAGE_SELECT_BITS_A_LSB +: VOLTAGE_SELECT_BITS_W]) &&
		!overheat_flag;
	assign next_enable_b = chan_active(voltage_select_bits[VOLTAGE_SELECT_BITS_B_LSB +: VOLTAGE_SELECT_BITS_W]) &&
		!overheat_flag;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_supply_enable_a <= 1'b0;
			o_supply_enable_b <= 1'b0;
		end else begin
			o_supply_enable_a <= next_enable_a;
			o_supply_enable_b <= next_enable_b;
		end
	end

	assign o_voltage_select_a = voltage_select_bits[VOLTAGE_SELECT_BITS_A_LSB +: VOLTAGE_SELECT_BITS_W];
	assign o_voltage_select_b = voltage_select_bits[VOLTAGE_SELECT_BITS_B_LSB +: VOLTAGE_SELECT_BITS_W];

	// read mux, registered one cycle after the address
	always_comb begin
		unique case (i_reg_addr)
			ADDR_STATUS_PRI: next_rdata = status_pri;
			ADDR_STATUS_SEC: next_rdata = STATUS_SEC_VALUE;
			ADDR_VOLTAGE_SELECT_BITS:       next_rdata = voltage_select_bits;
			ADDR_PROT_CTRL:  next_rdata = prot_ctrl;
			default:         next_rdata = READ_UNMAPPED;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_reg_rdata <= READ_UNMAPPED;
		end else begin
			o_reg_rdata <= next_rdata;
		end
	end

	// widths the bit map relies on
	if (DATA_W != 2 * VOLTAGE_SELECT_BITS_W) begin : g_bad_voltage_select_bits_w
		$error("select nibbles must fill the data byte");
	end
	if (COND_W != 4) begin : g_bad_cond_w
		$error("four condition inputs are expected");
	end
	if (ADDR_W < 3) begin : g_bad_addr_w
		$error("address too narrow for the register map");
	end

	// checks
	ctrl_readback_a:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		wr_ctrl ##1 (i_reg_addr == ADDR_PROT_CTRL && !i_reg_wr)
		|=> o_reg_rdata == $past(i_reg_wdata, 2))
		else $error("control register did not read back");

	ctrl_write_a:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		wr_ctrl |=> prot_ctrl == $past(i_reg_wdata))
		else $error("control write did not land");

	ctrl_hold_a:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!wr_ctrl |=> $stable(prot_ctrl))
		else $error("control register changed without write");

	overload_clear_a_a:
	assert property (@(posedge i_clk_sys)
		disable iff (i_rst)
		(overload_restart_mode && overcurrent_flag_chan_a)
		|=> o_voltage_select_a == VOLTAGE_SELECT_BITS_STANDBY)
		else $error("channel a selects kept during overload");

	overload_clear_b_a:
	assert property (@(posedge i_clk_sys)
		disable iff (i_rst)
		(overload_restart_mode && overcurrent_flag_chan_b)
		|=> o_voltage_select_b == VOLTAGE_SELECT_BITS_STANDBY ##1 !o_supply_enable_b)
		else $error("channel b not shut down on overload");

	overload_keep_a:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(!overload_restart_mode && overcurrent_flag_chan_a && !wr_voltage_select_bits
		&& !(thermal_restart_mode && overheat_flag))
		|=> $stable(o_voltage_select_a))
		else $error("channel a selects lost with restart mode clear");

	thermal_clear_a:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(thermal_restart_mode && overheat_flag)
		|=> (voltage_select_bits == RESET_VOLTAGE_SELECT_BITS) && !o_supply_enable_a
		&& !o_supply_enable_b)
		else $error("selects not cleared on overheat");

	thermal_keep_a:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(!thermal_restart_mode && overheat_flag && !wr_voltage_select_bits
		&& !overload_restart_mode) |=> $stable(voltage_select_bits))
		else $error("selects lost during auto restart overheat");

	heat_off_a:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		overheat_flag |=> !o_supply_enable_a && !o_supply_enable_b)
		else $error("output enabled during overheat");

	heat_resume_a:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(!thermal_restart_mode && $fell(overheat_flag)
		&& chan_active(o_voltage_select_b)) |=> o_supply_enable_b)
		else $error("channel b output did not resume");

	auto_restore_a:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(!overheat_flag && chan_active(o_voltage_select_a))
		|=> o_supply_enable_a)
		else $error("channel a output did not resume");

	standby_off_a:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(o_voltage_select_b == VOLTAGE_SELECT_BITS_STANDBY) |=> !o_supply_enable_b)
		else $error("channel b enabled in standby");

	enable_sel_a:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		o_supply_enable_a |-> $past(chan_active(o_voltage_select_a)))
		else $error("channel a enabled from standby");

	voltage_select_bits_write_a:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(wr_voltage_select_bits && !(overload_restart_mode && (overcurrent_flag_chan_a
		|| overcurrent_flag_chan_b))
		&& !(thermal_restart_mode && overheat_flag))
		|=> voltage_select_bits == $past(i_reg_wdata))
		else $error("select write did not land");

	voltage_select_bits_hold_a:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(!wr_voltage_select_bits && !(overload_restart_mode && (overcurrent_flag_chan_a
		|| overcurrent_flag_chan_b))
		&& !(thermal_restart_mode && overheat_flag)) |=> $stable(voltage_select_bits))
		else $error("select bits changed without cause");

	rd_voltage_select_bits_a:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_reg_addr == ADDR_VOLTAGE_SELECT_BITS) |=> o_reg_rdata == $past(voltage_select_bits))
		else $error("select register read mismatch");

	status_follow_a:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_reg_addr == ADDR_STATUS_PRI) |=>
		o_reg_rdata == {$past(cond_sync[COND_LOW_SUPPLY]),
		$past(cond_sync[COND_OVERHEAT]), 4'h0,
		$past(cond_sync[COND_OC_B]), $past(cond_sync[COND_OC_A])})
		else $error("primary status mismatch");

	sync_follow_a:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(!$past(i_rst) && !$past(i_rst, 2)) |->
		cond_sync == $past({i_low_supply, i_overheat,
		i_overcurrent_chan_b, i_overcurrent_chan_a}, 2))
		else $error("flags do not follow conditions");

	status_sec_a:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_reg_addr == ADDR_STATUS_SEC) |=> o_reg_rdata == 8'h00)
		else $error("secondary status not zero");

	status_ro_a:
	assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_reg_wr && (i_reg_addr == ADDR_STATUS_PRI
		|| i_reg_addr == ADDR_STATUS_SEC)) |=> $stable(prot_ctrl))
		else $error("status write changed control");

	reset_zero_a:
	assert property (@(posedge i_clk_sys)
		$past(i_rst) |-> (prot_ctrl == 8'h00) && (voltage_select_bits == 8'h00)
		&& (o_reg_rdata == 8'h00))
		else $error("registers not zero after reset");

	cover_overload_c: cover property (@(posedge i_clk_sys) disable iff (i_rst)
		overload_restart_mode && chan_active(o_voltage_select_a)
		##1 overcurrent_flag_chan_a ##2 !o_supply_enable_a);

	cover_auto_restore_c: cover property (@(posedge i_clk_sys)
		disable iff (i_rst)
		!thermal_restart_mode && overheat_flag && chan_active(o_voltage_select_a)
		##1 !overheat_flag ##1 o_supply_enable_a);

	cover_ctrl_write_c: cover property (@(posedge i_clk_sys)
		disable iff (i_rst) wr_ctrl ##1 thermal_restart_mode);

	cover_heat_clear_c: cover property (@(posedge i_clk_sys)
		disable iff (i_rst)
		thermal_restart_mode && overheat_flag ##1 voltage_select_bits == RESET_VOLTAGE_SELECT_BITS);

	cover_low_supply_c: cover property (@(posedge i_clk_sys)
		disable iff (i_rst)
		(i_reg_addr == ADDR_STATUS_PRI) && low_supply_flag);

endmodule

/* tb_top.sv */
// self-checking bench for the protection and diagnostic registers
module tb_top
	import lnb_protection_diag_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic       i_clk_sys, i_rst, wr, oc_a, oc_b, heat, low;
	logic [7:0] addr, wdata, rdata;
	logic [3:0] vs_a, vs_b;
	logic       en_a, en_b;
	int         bad_count, n_compared;
	lnb_protection_diag_regs uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.o_reg_rdata(rdata), .i_overcurrent_chan_a(oc_a),
		.i_overcurrent_chan_b(oc_b), .i_overheat(heat), .i_low_supply(low),
		.o_voltage_select_a(vs_a), .o_voltage_select_b(vs_b),
		.o_supply_enable_a(en_a), .o_supply_enable_b(en_b));
	lnb_host_model host (.i_clk_sys(i_clk_sys), .i_reg_rdata(rdata),
		.o_reg_wr(wr), .o_reg_addr(addr), .o_reg_wdata(wdata));
	task automatic check(input string n, input logic [7:0] s, e);
		n_compared++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rchk(input string n, input logic [7:0] a, e);
		logic [7:0] v;
		host.rd(a, v);
		check(n, v, e);
	endtask
	task automatic outs(input string n, input logic [7:0] vs,
		input logic [1:0] en);
		check({n, " voltage_select_bits"}, {vs_b, vs_a}, vs);
		check({n, " en"}, {6'h00, en_b, en_a}, {6'h00, en});
	endtask
	task automatic idle;
		repeat (2) @(posedge i_clk_sys);
		#1;
	endtask
	// drives {low, heat, oc_b, oc_a} and lets sync and clearing land
	task automatic cond(input logic [3:0] c);
		@(posedge i_clk_sys);
		{low, heat, oc_b, oc_a} <= c;
		repeat (5) @(posedge i_clk_sys);
		#1;
	endtask
	task automatic t_reset;
		outs("reset", 8'h00, 2'b00);
		rchk("pri", ADDR_STATUS_PRI, 8'h00);
		rchk("sec", ADDR_STATUS_SEC, 8'h00);
		rchk("ctrl", ADDR_PROT_CTRL, 8'h00);
	endtask
	task automatic t_access;
		host.wr(ADDR_PROT_CTRL, 8'h48);
		rchk("ctrl", ADDR_PROT_CTRL, 8'h48);
		host.wr(ADDR_STATUS_PRI, 8'hFF);
		host.wr(ADDR_STATUS_SEC, 8'hFF);
		rchk("pri ro", ADDR_STATUS_PRI, 8'h00);
		rchk("sec ro", ADDR_STATUS_SEC, 8'h00);
	endtask
	task automatic t_flags;
		logic [7:0] exp [4];
		exp = '{8'h01, 8'h02, 8'h40, 8'h80};
		for (int i = 0; i < 4; i++) begin
			cond(4'h1 << i);
			rchk("flag", ADDR_STATUS_PRI, exp[i]);
		end
		cond(4'hF);
		rchk("all flags", ADDR_STATUS_PRI, 8'hC3);
		cond(4'h0);
		rchk("flags gone", ADDR_STATUS_PRI, 8'h00);
	endtask
	task automatic t_overload;
		host.wr(ADDR_PROT_CTRL, 8'h08);
		host.wr(ADDR_VOLTAGE_SELECT_BITS, 8'h35);
		idle();
		outs("on", 8'h35, 2'b11);
		cond(4'h1);
		outs("ol", 8'h30, 2'b10);
		cond(4'h0);
		outs("ol off", 8'h30, 2'b10);
		host.wr(ADDR_VOLTAGE_SELECT_BITS, 8'h35);
		idle();
		outs("ol rewrite", 8'h35, 2'b11);
		host.wr(ADDR_PROT_CTRL, 8'h00);
		cond(4'h3);
		outs("ol keep", 8'h35, 2'b11);
		cond(4'h0);
	endtask
	task automatic t_rerst;
		host.wr(ADDR_PROT_CTRL, 8'h48);
		host.wr(ADDR_VOLTAGE_SELECT_BITS, 8'h35);
		@(posedge i_clk_sys);
		{low, heat, oc_b, oc_a} <= 4'h8;
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		@(posedge i_clk_sys);
		#1;
		outs("rerst", 8'h00, 2'b00);
		rchk("rerst ctrl", ADDR_PROT_CTRL, 8'h00);
		rchk("rerst voltage_select_bits", ADDR_VOLTAGE_SELECT_BITS, 8'h00);
		rchk("rerst pri", ADDR_STATUS_PRI, 8'h80);
		cond(4'h0);
	endtask
	task automatic t_thermal;
		host.wr(ADDR_PROT_CTRL, 8'h40);
		cond(4'h4);
		outs("ot1", 8'h00, 2'b00);
		rchk("ot1 voltage_select_bits", ADDR_VOLTAGE_SELECT_BITS, 8'h00);
		cond(4'h0);
		outs("ot1 off", 8'h00, 2'b00);
		host.wr(ADDR_VOLTAGE_SELECT_BITS, 8'h35);
		host.wr(ADDR_PROT_CTRL, 8'h00);
		cond(4'h4);
		outs("ot0", 8'h35, 2'b00);
		cond(4'h0);
		outs("ot0 off", 8'h35, 2'b11);
	endtask
	task automatic wrap_up;
		if (bad_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		i_clk_sys = 1'b0;
		forever #20 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		#200000;
		bad_count++;
		wrap_up();
	end
	initial begin
		bad_count = 0;
		n_compared = 0;
		i_rst = 1'b1;
		{low, heat, oc_b, oc_a} = 4'h0;
		repeat (10) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		@(posedge i_clk_sys);
		#1;
		t_reset();
		t_access();
		t_flags();
		t_overload();
		t_thermal();
		t_rerst();
		wrap_up();
	end
endmodule
